// *** verilog/servo_stop_pkg.sv ***
// Constants shared by the servo fault-stop controller
package servo_stop_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CLASS2_MODE   = 8'h00;
	localparam logic [7:0] OFS_CLASS3_MODE   = 8'h04;
	localparam logic [7:0] OFS_OT_MODE       = 8'h08;
	localparam logic [7:0] OFS_FAST_RAMP     = 8'h0c;
	localparam logic [7:0] OFS_SLOW_RAMP     = 8'h10;
	localparam logic [7:0] OFS_BRAKE_CURRENT = 8'h14;
	localparam logic [7:0] OFS_RATED_SPEED   = 8'h18;
	localparam logic [7:0] OFS_STATE         = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STATUS    = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK      = 8'h24;
	localparam logic [7:0] OFS_CONTROL       = 8'h28;

	// Reset values
	localparam logic [15:0] RST_STOP_MODE     = 16'h0000;
	localparam logic [15:0] RST_FAST_RAMP     = 16'h01f4;
	localparam logic [15:0] RST_SLOW_RAMP     = 16'h03e8;
	localparam logic [15:0] RST_BRAKE_CURRENT = 16'h0000;
	localparam logic [15:0] RST_RATED_SPEED   = 16'h0bb8;
	localparam logic [4:0]  RST_IRQ_MASK      = 5'h00;

	// Fault code class boundaries
	localparam logic [9:0] CLASS1_LO = 10'd100;
	localparam logic [9:0] CLASS1_HI = 10'd199;
	localparam logic [9:0] CLASS2_LO = 10'd200;
	localparam logic [9:0] CLASS2_HI = 10'd599;
	localparam logic [9:0] CLASS3_LO = 10'd600;
	localparam logic [9:0] CLASS3_HI = 10'd999;

	// Stop source rank; higher is more severe
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_OT   = 3'h1;
	localparam logic [2:0] SRC_C3   = 3'h2;
	localparam logic [2:0] SRC_C2   = 3'h3;
	localparam logic [2:0] SRC_C1   = 3'h4;

	// Stop mode codes
	localparam logic [15:0] MODE_COAST      = 16'h0000;
	localparam logic [15:0] MODE_FAST_OFF   = 16'h0001;
	localparam logic [15:0] MODE_SLOW_OFF   = 16'h0002;
	localparam logic [15:0] MODE_FAST_HOLD  = 16'h0003;
	localparam logic [15:0] MODE_SLOW_HOLD  = 16'h0004;
	localparam logic [15:0] MODE_BRAKE      = 16'h0005;

	// Interrupt status bit positions
	localparam int IRQ_CLASS1 = 0;
	localparam int IRQ_CLASS2 = 1;
	localparam int IRQ_CLASS3 = 2;
	localparam int IRQ_OT     = 3;
	localparam int IRQ_STOPPED = 4;

	// Control register bit
	localparam int CTRL_FAULT_RESET = 0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [5:0] {
		ST_RUN   = 6'b000001,
		ST_COAST = 6'b000010,
		ST_RAMP  = 6'b000100,
		ST_BRAKE = 6'b001000,
		ST_HOLD  = 6'b010000,
		ST_OFF   = 6'b100000
	} stop_state_t;

endpackage : servo_stop_pkg

// *** verilog/servo_fault_stop_control.sv ***
// Servo fault-stop controller with AXI4-Lite register access
//
// Function
// - Fault codes 100 to 199 are sorted into Class I.
// - A Class I fault removes motor power at once and lets the motor coast, ignoring every stop mode.
// - Fault codes 200 to 599 are Class II and stop by the Class II stop mode.
// - Fault codes 600 to 999 are Class III and stop by the Class III stop mode.
// - A travel limit event stops by its own over-travel stop mode, apart from the class modes.
// - Stop modes 0 to 5 mean coast, fast ramp off, slow ramp off, fast ramp hold, slow ramp hold, current brake.
// - Coasting stops driving the motor entirely.
// - During a ramp the motor stays energized and its speed is driven down.
// - Ramp-then-disable modes switch off drive and motor power at zero speed.
// - Hold modes keep the drive enabled at zero speed until the operator drops the enable input.
// - The fast ramp time is a 0 to 65535 ms setting, default 500.
// - The slow ramp time is its own ms setting, default 1000.
// - A ramp time is the time to decelerate from rated speed to zero.
// - The real ramp lasts the set time times fault speed over rated speed.
// - Mode 5 brakes with the current held in the braking current setting.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module servo_fault_stop_control #(
	parameter int CYC_PER_MS = servo_stop_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Fault and limit events from drive logic
	input  wire logic        fault_valid,
	input  wire logic [9:0]  fault_code,
	input  wire logic        limit_hit,
	input  wire logic [15:0] motor_speed,
	// Operator enable pin
	input  wire logic        enable_in,
	// Power stage
	output logic             motor_power,
	output logic             drive_enable,
	output logic             speed_override,
	output logic [15:0]      speed_ref,
	output logic             brake_on,
	output logic [15:0]      brake_current,
	// Interrupt
	output logic             irq
);

	typedef struct packed {
		// Stop sequencing and settings
		servo_stop_pkg::stop_state_t st;
		logic [2:0]  src;
		logic [15:0] mode2;
		logic [15:0] mode3;
		logic [15:0] mode_ot;
		logic [15:0] fast_ms;
		logic [15:0] slow_ms;
		logic [15:0] brk_cur;
		logic [15:0] rated;
		logic [4:0]  istat;
		logic [4:0]  imask;

		// Enable synchroniser and ramp bookkeeping
		logic        en_s1;
		logic        en_s2;
		logic [15:0] spd;
		logic [33:0] acc;

		// Registered power stage outputs
		logic        power;
		logic        drive;
		logic        ovr;
		logic        brake;
		logic [15:0] brake_i;
		logic        irq;

		// Register bus handshake
		logic        awrdy;
		logic        wrdy;
		logic        arrdy;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ctrl_t;

	ctrl_t q_reg;
	ctrl_t q_next;

	// Class rank of a fault code; codes outside all classes are ignored
	function automatic logic [2:0] classify(input logic [9:0] code);
		if (code >= servo_stop_pkg::CLASS1_LO && code <= servo_stop_pkg::CLASS1_HI)
			classify = servo_stop_pkg::SRC_C1;
		else if (code >= servo_stop_pkg::CLASS2_LO && code <= servo_stop_pkg::CLASS2_HI)
			classify = servo_stop_pkg::SRC_C2;
		else if (code >= servo_stop_pkg::CLASS3_LO && code <= servo_stop_pkg::CLASS3_HI)
			classify = servo_stop_pkg::SRC_C3;
		else
			classify = servo_stop_pkg::SRC_NONE;
	endfunction : classify

	// Live stop mode of a source, read straight from its register
	function automatic logic [15:0] mode_of(input logic [2:0] src, input ctrl_t s);
		unique case (src)
			servo_stop_pkg::SRC_C2: mode_of = s.mode2;
			servo_stop_pkg::SRC_C3: mode_of = s.mode3;
			servo_stop_pkg::SRC_OT: mode_of = s.mode_ot;
			default:                mode_of = servo_stop_pkg::MODE_COAST;
		endcase
	endfunction : mode_of

	// State that a stop mode leads to; unknown codes coast as the safe choice
	function automatic servo_stop_pkg::stop_state_t stop_state(input logic [15:0] m);
		if (m == servo_stop_pkg::MODE_BRAKE)
			stop_state = servo_stop_pkg::ST_BRAKE;
		else if (m >= servo_stop_pkg::MODE_FAST_OFF && m <= servo_stop_pkg::MODE_SLOW_HOLD)
			stop_state = servo_stop_pkg::ST_RAMP;
		else
			stop_state = servo_stop_pkg::ST_COAST;
	endfunction : stop_state

	// Byte lanes 0 and 1 carry a 16-bit setting
	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		wmerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction : wmerge

	// Unused upper bits read as zero
	function automatic logic [31:0] rd_word(input logic [7:0] a, input ctrl_t s);
		unique case (a)
			servo_stop_pkg::OFS_CLASS2_MODE:   rd_word = {16'h0000, s.mode2};
			servo_stop_pkg::OFS_CLASS3_MODE:   rd_word = {16'h0000, s.mode3};
			servo_stop_pkg::OFS_OT_MODE:       rd_word = {16'h0000, s.mode_ot};
			servo_stop_pkg::OFS_FAST_RAMP:     rd_word = {16'h0000, s.fast_ms};
			servo_stop_pkg::OFS_SLOW_RAMP:     rd_word = {16'h0000, s.slow_ms};
			servo_stop_pkg::OFS_BRAKE_CURRENT: rd_word = {16'h0000, s.brk_cur};
			servo_stop_pkg::OFS_RATED_SPEED:   rd_word = {16'h0000, s.rated};
			servo_stop_pkg::OFS_STATE:         rd_word = {s.spd, 5'h00, s.src, 2'h0, s.st};
			servo_stop_pkg::OFS_IRQ_STATUS:    rd_word = {27'h0000000, s.istat};
			servo_stop_pkg::OFS_IRQ_MASK:      rd_word = {27'h0000000, s.imask};
			default:                           rd_word = 32'h00000000;
		endcase
	endfunction : rd_word

	// Aligned and inside the map; anything else answers with an error
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= servo_stop_pkg::OFS_CONTROL);
	endfunction : mapped

	always_comb begin
		logic [2:0]  new_src;
		logic [4:0]  ev;
		logic        rd_clr;
		logic        fault_rst;
		logic [15:0] mode;
		logic [15:0] ramp_ms;
		logic [33:0] span;
		logic [33:0] acc_sum;
		q_next    = q_reg;
		ev        = 5'h00;
		rd_clr    = 1'b0;
		fault_rst = 1'b0;
		mode      = servo_stop_pkg::MODE_COAST;
		ramp_ms   = 16'h0000;
		span      = 34'h000000000;
		acc_sum   = 34'h000000000;
		new_src   = servo_stop_pkg::SRC_NONE;

		// Enable pin synchroniser
		q_next.en_s1 = enable_in;
		q_next.en_s2 = q_reg.en_s1;

		// Write channel: address and data may arrive in either order
		if (s_axi_awvalid && q_reg.awrdy) begin
			q_next.aw_got = 1'b1;
			q_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q_reg.wrdy) begin
			q_next.w_got = 1'b1;
			q_next.wdata = s_axi_wdata;
			q_next.wstrb = s_axi_wstrb;
		end
		if (q_reg.bvalid && s_axi_bready)
			q_next.bvalid = 1'b0;
		if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
			q_next.aw_got = 1'b0;
			q_next.w_got  = 1'b0;
			q_next.bvalid = 1'b1;
			q_next.bresp  = mapped(q_reg.awaddr) ? servo_stop_pkg::RESP_OKAY : servo_stop_pkg::RESP_SLVERR;
			unique case (q_reg.awaddr)
				servo_stop_pkg::OFS_CLASS2_MODE:
					q_next.mode2 = wmerge(q_reg.mode2, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_CLASS3_MODE:
					q_next.mode3 = wmerge(q_reg.mode3, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_OT_MODE:
					q_next.mode_ot = wmerge(q_reg.mode_ot, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_FAST_RAMP:
					q_next.fast_ms = wmerge(q_reg.fast_ms, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_SLOW_RAMP:
					q_next.slow_ms = wmerge(q_reg.slow_ms, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_BRAKE_CURRENT:
					q_next.brk_cur = wmerge(q_reg.brk_cur, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_RATED_SPEED:
					q_next.rated = wmerge(q_reg.rated, q_reg.wdata, q_reg.wstrb);
				servo_stop_pkg::OFS_IRQ_MASK:
					if (q_reg.wstrb[0])
						q_next.imask = q_reg.wdata[4:0];
				servo_stop_pkg::OFS_CONTROL:
					fault_rst = q_reg.wstrb[0] && q_reg.wdata[servo_stop_pkg::CTRL_FAULT_RESET];
				default: ;
			endcase
		end

		// Read channel; status clears on the read that returns it
		if (q_reg.rvalid && s_axi_rready)
			q_next.rvalid = 1'b0;
		if (s_axi_arvalid && q_reg.arrdy) begin
			q_next.rvalid = 1'b1;
			q_next.rdata  = rd_word(s_axi_araddr, q_reg);
			q_next.rresp  = mapped(s_axi_araddr) ? servo_stop_pkg::RESP_OKAY : servo_stop_pkg::RESP_SLVERR;
			rd_clr        = (s_axi_araddr == servo_stop_pkg::OFS_IRQ_STATUS);
		end

		// Incoming event, graded by severity
		new_src = fault_valid ? classify(fault_code) : servo_stop_pkg::SRC_NONE;
		if (new_src == servo_stop_pkg::SRC_NONE && limit_hit)
			new_src = servo_stop_pkg::SRC_OT;
		unique case (new_src)
			servo_stop_pkg::SRC_C1: ev[servo_stop_pkg::IRQ_CLASS1] = 1'b1;
			servo_stop_pkg::SRC_C2: ev[servo_stop_pkg::IRQ_CLASS2] = 1'b1;
			servo_stop_pkg::SRC_C3: ev[servo_stop_pkg::IRQ_CLASS3] = 1'b1;
			servo_stop_pkg::SRC_OT: ev[servo_stop_pkg::IRQ_OT]     = 1'b1;
			default: ;
		endcase

		// A lesser event never replaces a more severe stop in progress
		if (new_src > q_reg.src) begin
			q_next.src = new_src;
			q_next.acc = 34'h000000000;
			if (q_reg.st == servo_stop_pkg::ST_RUN || q_reg.st == servo_stop_pkg::ST_HOLD)
				q_next.spd = motor_speed;
			q_next.st = stop_state(mode_of(new_src, q_reg));
		end else begin
			mode = mode_of(q_reg.src, q_reg);
			unique case (q_reg.st)
				servo_stop_pkg::ST_RUN: begin
					q_next.spd = motor_speed;
				end
				servo_stop_pkg::ST_RAMP, servo_stop_pkg::ST_BRAKE: begin
					// Mode edits during a stop switch the stop style at once
					q_next.st = stop_state(mode);
					if (q_reg.st == servo_stop_pkg::ST_RAMP && q_next.st == servo_stop_pkg::ST_RAMP) begin
						if (mode == servo_stop_pkg::MODE_FAST_OFF || mode == servo_stop_pkg::MODE_FAST_HOLD)
							ramp_ms = q_reg.fast_ms;
						else
							ramp_ms = q_reg.slow_ms;
						// One count of speed per span/rated cycles: rated to zero takes ramp_ms
						span    = 34'(ramp_ms) * 34'(CYC_PER_MS);
						acc_sum = q_reg.acc + 34'(q_reg.rated);
						if (q_reg.spd == 16'h0000) begin
							q_next.acc = 34'h000000000;
							ev[servo_stop_pkg::IRQ_STOPPED] = 1'b1;
							if (mode == servo_stop_pkg::MODE_FAST_HOLD || mode == servo_stop_pkg::MODE_SLOW_HOLD)
								q_next.st = servo_stop_pkg::ST_HOLD;
							else
								q_next.st = servo_stop_pkg::ST_OFF;
						end else if (span == 34'h000000000) begin
							q_next.spd = 16'h0000;
						end else if (acc_sum >= span) begin
							q_next.acc = acc_sum - span;
							q_next.spd = q_reg.spd - 16'h0001;
						end else begin
							q_next.acc = acc_sum;
						end
					end else if (q_next.st == servo_stop_pkg::ST_BRAKE && motor_speed == 16'h0000) begin
						q_next.st = servo_stop_pkg::ST_OFF;
						ev[servo_stop_pkg::IRQ_STOPPED] = 1'b1;
					end
				end
				servo_stop_pkg::ST_HOLD: begin
					if (!q_reg.en_s2)
						q_next.st = servo_stop_pkg::ST_OFF;
				end
				servo_stop_pkg::ST_COAST, servo_stop_pkg::ST_OFF: ;
			endcase
			// A fault reset cannot cut short a ramp or brake still under way
			if (fault_rst && q_reg.st != servo_stop_pkg::ST_RAMP && q_reg.st != servo_stop_pkg::ST_BRAKE) begin
				q_next.st  = servo_stop_pkg::ST_RUN;
				q_next.src = servo_stop_pkg::SRC_NONE;
			end
		end

		// Power stage outputs from the coming state
		q_next.power   = q_next.st != servo_stop_pkg::ST_COAST && q_next.st != servo_stop_pkg::ST_OFF;
		q_next.drive   = q_next.st == servo_stop_pkg::ST_RUN ? q_reg.en_s2 : q_next.power;
		q_next.ovr     = q_next.st == servo_stop_pkg::ST_RAMP || q_next.st == servo_stop_pkg::ST_HOLD;
		q_next.brake   = q_next.st == servo_stop_pkg::ST_BRAKE;
		q_next.brake_i = q_next.st == servo_stop_pkg::ST_BRAKE ? q_reg.brk_cur : 16'h0000;
		// Hold parks the motor at zero speed under power
		if (q_next.st == servo_stop_pkg::ST_HOLD)
			q_next.spd = 16'h0000;

		// Sticky status: a new event wins over the clearing read
		q_next.istat = (rd_clr ? 5'h00 : q_reg.istat) | ev;
		q_next.irq   = |(q_next.istat & q_next.imask);

		// One write and one read at a time; ready returns after the answer
		q_next.awrdy = !q_next.aw_got && !q_next.bvalid;
		q_next.wrdy  = !q_next.w_got && !q_next.bvalid;
		q_next.arrdy = !q_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Clear everything, then load the setting defaults
			q_reg         <= '0;
			q_reg.st      <= servo_stop_pkg::ST_RUN;
			q_reg.src     <= servo_stop_pkg::SRC_NONE;
			q_reg.mode2   <= servo_stop_pkg::RST_STOP_MODE;
			q_reg.mode3   <= servo_stop_pkg::RST_STOP_MODE;
			q_reg.mode_ot <= servo_stop_pkg::RST_STOP_MODE;
			q_reg.fast_ms <= servo_stop_pkg::RST_FAST_RAMP;
			q_reg.slow_ms <= servo_stop_pkg::RST_SLOW_RAMP;
			q_reg.brk_cur <= servo_stop_pkg::RST_BRAKE_CURRENT;
			q_reg.rated   <= servo_stop_pkg::RST_RATED_SPEED;
			q_reg.imask   <= servo_stop_pkg::RST_IRQ_MASK;
		end else begin
			q_reg <= q_next;
		end
	end

	assign s_axi_awready  = q_reg.awrdy;
	assign s_axi_wready   = q_reg.wrdy;
	assign s_axi_bvalid   = q_reg.bvalid;
	assign s_axi_bresp    = q_reg.bresp;
	assign s_axi_arready  = q_reg.arrdy;
	assign s_axi_rvalid   = q_reg.rvalid;
	assign s_axi_rdata    = q_reg.rdata;
	assign s_axi_rresp    = q_reg.rresp;
	assign motor_power    = q_reg.power;
	assign drive_enable   = q_reg.drive;
	assign speed_override = q_reg.ovr;
	assign speed_ref      = q_reg.spd;
	assign brake_on       = q_reg.brake;
	assign brake_current  = q_reg.brake_i;
	assign irq            = q_reg.irq;

endmodule : servo_fault_stop_control

// *** verification/servo_fault_stop_control_sva.sv ***
// Port-level assertions for the servo fault-stop controller
`timescale 1ns/10ps
module servo_fault_stop_control_sva #(
	parameter int CYC_PER_MS = servo_stop_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Events
	input wire logic        fault_valid,
	input wire logic [9:0]  fault_code,
	input wire logic        limit_hit,
	input wire logic [15:0] motor_speed,
	input wire logic        enable_in,
	// Power stage
	input wire logic        motor_power,
	input wire logic        drive_enable,
	input wire logic        speed_override,
	input wire logic [15:0] speed_ref,
	input wire logic        brake_on,
	input wire logic [15:0] brake_current,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_class1;
		fault_valid && fault_code >= 10'h064 && fault_code <= 10'h0c7;
	endsequence
	sequence s_run;
		motor_power && !speed_override && !brake_on;
	endsequence
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	property p_class1_coast;
		s_class1 |=> !motor_power && !drive_enable;
	endproperty
	property p_class1_stays;
		s_class1 |=> (!motor_power)[*3];
	endproperty
	property p_bad_code;
		s_run and (fault_valid && (fault_code < 10'h064 || fault_code > 10'h3e7) && !limit_hit) |=> s_run;
	endproperty
	property p_unpowered;
		!motor_power |-> !drive_enable && !speed_override;
	endproperty
	property p_ramp_energized;
		speed_override |-> motor_power && drive_enable;
	endproperty
	property p_ramp_down;
		speed_override && $past(speed_override) |-> speed_ref <= $past(speed_ref);
	endproperty
	property p_brake_current;
		!brake_on |-> brake_current == 16'h0000;
	endproperty
	property p_wr_answer;
		s_wr_both |-> ##2 s_axi_bvalid;
	endproperty
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty

	a_class1_coast: assert property (p_class1_coast) else $error("class one fault left power on");
	a_class1_stays: assert property (p_class1_stays) else $error("class one coast not held");
	a_bad_code: assert property (p_bad_code) else $error("unclassed code left run");
	a_unpowered: assert property (p_unpowered) else $error("drive active without power");
	a_ramp_energized: assert property (p_ramp_energized) else $error("ramp without power");
	a_ramp_down: assert property (p_ramp_down) else $error("speed reference rose during stop");
	a_brake_current: assert property (p_brake_current) else $error("brake current outside brake");
	a_wr_answer: assert property (p_wr_answer) else $error("write response late");
	a_b_stands: assert property (p_b_stands) else $error("write response dropped");
	a_rd_answer: assert property (p_rd_answer) else $error("read data late");
endmodule : servo_fault_stop_control_sva

bind servo_fault_stop_control servo_fault_stop_control_sva #(.CYC_PER_MS(CYC_PER_MS)) i_sva (.*);

// *** verification/motor_load_model.sv ***
// Motor and load behind the power stage
`timescale 1ns/10ps
module motor_load_model (
	// Clock and reset
	input wire logic         aclk,
	input wire logic         aresetn,
	// Power stage
	input wire logic         motor_power,
	input wire logic         speed_override,
	input wire logic  [15:0] speed_ref,
	input wire logic         brake_on,
	input wire logic  [15:0] run_speed,
	// Load
	output logic      [15:0] motor_speed
);
	logic [2:0] fric;

	// Coasting loses speed slowly so a stop is never instant
	always_ff @(posedge aclk) begin
		fric <= aresetn ? fric + 3'h1 : 3'h0;
		if (!aresetn) begin
			motor_speed <= 16'h0000;
		end else if (motor_power && speed_override) begin
			motor_speed <= speed_ref;
		end else if (brake_on && motor_speed != 16'h0000) begin
			motor_speed <= motor_speed - 16'h0001;
		end else if (!motor_power && motor_speed != 16'h0000 && fric == 3'h0) begin
			motor_speed <= motor_speed - 16'h0001;
		end else if (motor_power && !brake_on) begin
			motor_speed <= run_speed;
		end
	end
endmodule : motor_load_model

// *** verification/servo_fault_stop_control_tb.sv ***
// Self-checking bench for the servo fault-stop controller
`timescale 1ns/10ps
module servo_fault_stop_control_tb;
	localparam int CYC   = 10;
	localparam int RATED = 10;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        fault_valid, limit_hit, enable_in, motor_power, drive_enable, speed_override, brake_on, irq;
	logic [9:0]  fault_code;
	logic [15:0] motor_speed, speed_ref, brake_current, run_speed;
	int          fail_count, cmp_count, seed, regs[0:5];

	servo_fault_stop_control #(.CYC_PER_MS(CYC)) i_servo_fault_stop_control (.*);
	motor_load_model i_motor_load_model (.aclk(aclk), .aresetn(aresetn), .motor_power(motor_power),
		.speed_override(speed_override), .speed_ref(speed_ref), .brake_on(brake_on),
		.run_speed(run_speed), .motor_speed(motor_speed));

	always #5 aclk = ~aclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic tick(input int k);
		repeat (k) @(negedge aclk);
	endtask : tick

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 100);
		while (!s_axi_bvalid && n < 200) begin
			@(posedge aclk);
			n++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 200) fail_count++;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 100);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_rvalid && n < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 200) fail_count++;
	endtask : axi_rd

	// Keeps the bench copy of the six settings below 8'h18 in step with each write to them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		chk(rsp, 2'h0);
		if (a < 8'h18) regs[a[7:2]] = d & 32'hffff;
	endtask : wr

	// A negative code raises the travel limit instead of a fault
	task automatic fire(input int code);
		@(posedge aclk);
		if (code < 0) limit_hit <= 1'b1;
		else fault_valid <= 1'b1;
		fault_code <= code[9:0];
		@(posedge aclk);
		fault_valid <= 1'b0;
		limit_hit   <= 1'b0;
		@(negedge aclk);
	endtask : fire

	task automatic stop_case(input int s, input int m);
		int n, exp, brk;
		brk = {$random(seed)} % 65536;
		wr(8'h14, brk);
		for (int k = 0; k < 3; k++) wr(8'(k * 4), (k == s) ? m : (m + 1) % 6);
		fire((s == 2) ? -1 : 200 + 400 * s + {$random(seed)} % 400);
		n = 0;
		if (m == 0) begin
			chk(motor_power | drive_enable, 1'b0);
		end else if (m == 5) begin
			chk(brake_on, 1'b1);
			chk(brake_current, brk);
			while (motor_power && n < 300) begin tick(1); n++; end
			chk(motor_power, 1'b0);
		end else begin
			chk(speed_override, 1'b1);
			chk(speed_ref, 16'h0014);
			exp = regs[(m % 2) ? 3 : 4] * CYC * 20 / RATED;
			while (speed_ref !== 16'h0000 && n < 5000) begin tick(1); n++; end
			chk(n >= exp - 3 && n <= exp + 3, 1'b1);
			tick(3);
			chk({motor_power, drive_enable}, (m > 2) ? 2'h3 : 2'h0);
			if (m > 2) begin
				@(posedge aclk) enable_in <= 1'b0;
				tick(8);
				chk(motor_power, 1'b0);
				@(posedge aclk) enable_in <= 1'b1;
			end
		end
		wr(8'h28, 1);
		tick(4);
		chk(motor_power, 1'b1);
		$display("stop test source %0d mode %0d done", s, m);
	endtask : stop_case

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault_valid, fault_code, limit_hit} = '0;
		s_axi_wstrb = 4'hf;
		enable_in = 1'b1;
		run_speed = 16'h0014;
		seed = 32'h940d;
		fail_count = 0;
		cmp_count = 0;
		regs = '{0, 0, 0, 16'h01f4, 16'h03e8, 0};
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			axi_rd(8'(k * 4), rd, rsp);
			chk(rd, regs[k]);
		end
		axi_rd(8'h2c, rd, rsp);
		chk(rsp, 2'h2);
		chk(rd, 32'h0);
		axi_wr(8'h30, 32'h1, rsp);
		chk(rsp, 2'h2);
		wr(8'h18, RATED);
		wr(8'h0c, 3);
		wr(8'h10, 6);
		for (int k = 0; k < 3; k++) begin
			wr(8'(k * 4), {$random(seed)} % 6);
			axi_rd(8'(k * 4), rd, rsp);
			chk(rd, regs[k]);
		end
		$display("register test done");
		for (int s = 0; s < 3; s++) for (int m = 0; m < 6; m++) stop_case(s, m);
		wr(8'h24, 1);
		wr(8'h00, 2);
		axi_rd(8'h20, rd, rsp);
		fire(300);
		tick(10);
		chk(speed_override, 1'b1);
		fire(100 + {$random(seed)} % 100);
		chk({motor_power, drive_enable, speed_override}, 3'h0);
		axi_rd(8'h1c, rd, rsp);
		chk(rd[10:0], 11'h402);
		tick(2);
		chk(irq, 1'b1);
		axi_rd(8'h20, rd, rsp);
		chk(rd, 32'h3);
		tick(2);
		chk(irq, 1'b0);
		wr(8'h28, 1);
		tick(4);
		$display("class one test done");
		fire(50);
		tick(2);
		chk({motor_power, speed_override}, 2'h2);
		wr(8'h00, 4);
		fire(250);
		tick(10);
		wr(8'h00, 0);
		tick(2);
		chk(motor_power, 1'b0);
		wr(8'h28, 1);
		$display("live setting test done");
		finish_test;
	end

	initial begin
		#200000;
		fail_count++;
		finish_test;
	end
endmodule : servo_fault_stop_control_tb
